/* File: sim/flash_command_write_and_reset_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    miscompares++; \
    $display("Error %0t: got %h expected %h", $time, (got), (exp)); end end
module flash_command_write_and_reset_tb
    import flash_cmd_pkg::*;
;
    localparam int WAIT_END = BUSY_CYCLES + 16;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, exp_flags;
    logic [2:0] hsize;
    logic reset_pin_n, pulse_overrun, ready_out, ready_oe, r0;
    logic ce_n, we_n, oe_n, avd_n, fclk;
    logic [23:0] faddr;
    logic [15:0] fdata, bank_busy, exp_cfg, exp_busy, cfg_w;
    int miscompares, num_checks;
    flash_command_write_and_reset flash_command_write_and_reset_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .reset_pin_n(reset_pin_n), .chip_enable_n(ce_n),
        .write_enable_n(we_n), .output_enable_n(oe_n),
        .address_valid_n(avd_n), .flash_clk(fclk), .flash_addr(faddr),
        .flash_data(fdata), .pulse_overrun(pulse_overrun),
        .ready_out(ready_out), .ready_oe(ready_oe), .bank_busy(bank_busy)
    );
    flash_host_model flash_host_model_i (
        .hclk(hclk), .chip_enable_n(ce_n), .write_enable_n(we_n),
        .output_enable_n(oe_n), .address_valid_n(avd_n), .flash_clk(fclk),
        .flash_addr(faddr), .flash_data(fdata)
    );
    // ----------------------------------------
    // Bus and flash tasks
    // ----------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        haddr <= {24'h00_0000, a};
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask : ahb
    task automatic run(input logic [3:0] b, input logic [15:0] q [$]);
        foreach (q[i]) flash_host_model_i.write_cycle({b, 20'($urandom)}, q[i]);
    endtask : run
    task automatic prog(input logic [3:0] b, input logic [15:0] d);
        run(b, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_PROGRAM, d});
    endtask : prog
    task automatic sprog(input logic [3:0] b, input logic [15:0] d);
        logic [15:0] q [$];
        q = {CMD_UNLOCK1, CMD_UNLOCK2, CMD_PROGRAM, d};
        foreach (q[i]) flash_host_model_i.sync_write({b, 20'($urandom)}, q[i]);
    endtask : sprog
    task automatic settle;
        repeat (WAIT_END) @(posedge hclk);
        exp_busy = 16'h0000;
    endtask : settle
    task automatic check_state;
        ahb(1'b0, CFG_OFFSET, 32'h0000_0000);
        `CHK(rd, {16'h0000, exp_cfg})
        ahb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        `CHK(rd[1:0], exp_flags)
        `CHK(bank_busy, exp_busy)
    endtask : check_state
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // Clock, watchdog and scenarios
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        repeat (30000) @(posedge hclk);
        miscompares++;
        report_and_stop;
    end
    initial begin
        {hsel, hwrite, hresetn, pulse_overrun} = 4'b0000;
        {haddr, hwdata, htrans, hsize} = '0;
        reset_pin_n = 1'b1;
        {miscompares, num_checks} = '0;
        {exp_cfg, exp_busy, exp_flags} = '0;
        void'($urandom(65));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        check_state;
        ahb(1'b0, 8'h10, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        r0 = ready_out;
        cfg_w = (16'($urandom) & 16'hBD00) | 16'h8400;
        ahb(1'b1, CFG_OFFSET, {16'h0000, cfg_w});
        exp_cfg = cfg_w;
        check_state;
        `CHK(ready_out, ~r0)
        sprog(4'h2, 16'h5A5A);
        exp_busy[2] = 1'b1;
        check_state;
        run(4'h2, '{CMD_RESET});
        `CHK(bank_busy, exp_busy)
        pulse_overrun <= 1'b1;
        repeat (2) @(posedge hclk);
        pulse_overrun <= 1'b0;
        ahb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        `CHK(rd[0], 1'b1)
        ahb(1'b1, STATUS_OFFSET, 32'h0000_0001);
        ahb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        `CHK(rd[0], 1'b0)
        run(4'h2, '{CMD_RESET});
        settle;
        ahb(1'b1, CFG_OFFSET, 32'h0000_0000);
        exp_cfg = 16'h0000;
        run(4'h3, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_PROGRAM, CMD_RESET});
        run(4'h3, '{16'h1111});
        check_state;
        run(4'h3, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_AUTOSEL, CMD_RESET});
        prog(4'h3, 16'h2222);
        exp_busy[3] = 1'b1;
        check_state;
        settle;
        run(4'h5, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_ERASE});
        run(4'h5, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_SECTOR});
        exp_busy[5] = 1'b1;
        check_state;
        settle;
        run(4'h4, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_BYPASS, CMD_RESET});
        // Still in bypass, so a full program sequence is swallowed
        prog(4'h4, 16'h3333);
        check_state;
        run(4'h4, '{CMD_BYPASS_EXIT, CMD_BYPASS_EXIT2});
        prog(4'h4, 16'h4444);
        exp_busy[4] = 1'b1;
        check_state;
        settle;
        run(4'h6, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_BUFFER, CMD_RESET});
        exp_flags[1] = 1'b1;
        check_state;
        run(4'h6, '{CMD_RESET});
        check_state;
        run(4'h6, '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_RESET});
        exp_flags[1] = 1'b0;
        check_state;
        fork
            flash_host_model_i.select_idle(8);
            begin
                repeat (6) @(posedge hclk);
                `CHK(ready_oe, 1'b1)
            end
        join
        repeat (4) @(posedge hclk);
        `CHK(ready_oe, 1'b0)
        ahb(1'b1, CFG_OFFSET, 32'h0000_0100);
        prog(4'h1, 16'h5555);
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge hclk);
        exp_busy = 16'h0000;
        exp_cfg = 16'h0000;
        `CHK(bank_busy, exp_busy)
        fork
            prog(4'h7, 16'h6666);
            begin
                repeat (8) @(posedge hclk);
                `CHK(ready_oe, 1'b0)
            end
        join
        check_state;
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge hclk);
        check_state;
        prog(4'h1, 16'h5555);
        exp_busy[1] = 1'b1;
        check_state;
        settle;
        check_state;
        report_and_stop;
    end
endmodule : flash_command_write_and_reset_tb
`default_nettype wire

/* File: sim/flash_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host controller driving the flash pins
// ----------------------------------------
module flash_host_model (
    input wire logic hclk,
    output logic chip_enable_n,
    output logic write_enable_n,
    output logic output_enable_n,
    output logic address_valid_n,
    output logic flash_clk,
    output logic [23:0] flash_addr,
    output logic [15:0] flash_data
);
    logic in_frame;
    initial begin
        chip_enable_n = 1'b1;
        write_enable_n = 1'b1;
        output_enable_n = 1'b1;
        address_valid_n = 1'b1;
        flash_clk = 1'b0;
        in_frame = 1'b0;
        flash_addr = 24'h00_0000;
        flash_data = 16'h0000;
    end
    // Link clock stands still outside frames
    always #160 flash_clk = in_frame ? ~flash_clk : 1'b0;
    // Six cycles per phase, so the two-flop sync always sees each strobe
    task automatic write_cycle(input logic [23:0] a, input logic [15:0] d);
        @(posedge hclk);
        in_frame <= 1'b1;
        chip_enable_n <= 1'b0;
        write_enable_n <= 1'b0;
        output_enable_n <= 1'b1;
        flash_addr <= a;
        flash_data <= d;
        repeat (6) @(posedge hclk);
        write_enable_n <= 1'b1;
        repeat (6) @(posedge hclk);
        chip_enable_n <= 1'b1;
        in_frame <= 1'b0;
        repeat (2) @(posedge hclk);
        // Two cycles after release the bus shows the inverse, not the stale value
        flash_addr <= ~a;
        flash_data <= ~d;
    endtask : write_cycle
    // Sync write: address under address-valid, then data under write enable
    task automatic sync_write(input logic [23:0] a, input logic [15:0] d);
        @(posedge hclk);
        in_frame <= 1'b1;
        chip_enable_n <= 1'b0;
        address_valid_n <= 1'b0;
        output_enable_n <= 1'b1;
        flash_addr <= a;
        flash_data <= d;
        // Long enough for one link clock rise to pass the synchroniser
        repeat (12) @(posedge hclk);
        address_valid_n <= 1'b1;
        write_enable_n <= 1'b0;
        repeat (6) @(posedge hclk);
        write_enable_n <= 1'b1;
        repeat (6) @(posedge hclk);
        chip_enable_n <= 1'b1;
        in_frame <= 1'b0;
        repeat (2) @(posedge hclk);
        flash_addr <= ~a;
        flash_data <= ~d;
    endtask : sync_write
    task automatic select_idle(input int n);
        @(posedge hclk);
        chip_enable_n <= 1'b0;
        repeat (n) @(posedge hclk);
        chip_enable_n <= 1'b1;
    endtask : select_idle
endmodule : flash_host_model
`default_nettype wire

/* File: src/flash_cmd_pkg.sv */
package flash_cmd_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CFG_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] OP_OFFSET = 8'h08;
    localparam logic [7:0] LAST_OFFSET = 8'h0C;
    // ----------------------------------------
    // Configuration fields
    // ----------------------------------------
    localparam int CFG_SYNC_BIT = 15;
    localparam int CFG_WAIT_LSB = 11;
    localparam int CFG_RDY_POL_BIT = 10;
    localparam int CFG_RDY_EARLY_BIT = 8;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // ----------------------------------------
    // Commands and geometry
    // ----------------------------------------
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [15:0] CMD_ERASE = 16'h0080;
    localparam logic [15:0] CMD_SECTOR = 16'h0030;
    localparam logic [15:0] CMD_CHIP = 16'h0010;
    localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
    localparam logic [15:0] CMD_BYPASS = 16'h0020;
    localparam logic [15:0] CMD_BUFFER = 16'h0025;
    localparam logic [15:0] CMD_BUF_CONFIRM = 16'h0029;
    localparam logic [15:0] CMD_BYPASS_EXIT = 16'h0090;
    localparam logic [15:0] CMD_BYPASS_EXIT2 = 16'h0000;
    localparam int NUM_BANKS = 16;
    localparam int BANK_LSB = 20;
    localparam int BOOT_SECTOR_KWORDS = 16;
    localparam int MAIN_SECTOR_KWORDS = 64;
    localparam int BUSY_CYCLES = 64;
    localparam logic [6:0] BUSY_COUNT = 7'(BUSY_CYCLES);

    typedef enum logic [3:0] {
        BK_READ = 4'h0,
        BK_UNL1 = 4'h1,
        BK_UNL2 = 4'h2,
        BK_PROG_SETUP = 4'h3,
        BK_BUSY = 4'h4,
        BK_AUTOSEL = 4'h5,
        BK_ERASE_SETUP = 4'h6,
        BK_ERASE_UNL1 = 4'h7,
        BK_ERASE_UNL2 = 4'h8,
        BK_SUSPENDED = 4'h9,
        BK_BYPASS = 4'hA,
        BK_BYPASS_EXIT = 4'hB,
        BK_BUF_ABORT = 4'hC,
        BK_FAILED = 4'hD,
        BK_BUF_LOAD = 4'hE
    } bank_state_t;

    typedef struct packed {
        logic [3:0] bank;
        logic [15:0] data;
    } flash_write_t;
endpackage : flash_cmd_pkg

/* File: src/flash_command_write_and_reset.sv */
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Async config accepts async writes, ignores clock
// - Sync config also takes clock-latched writes
// - Address at last fall, data first rise
// - Erase one sector or chip
// - Sixteen banks, boot sectors at ends
// - Ready output gated by chip enable
// - Bit 10 picks ready polarity
// - Bit 8 makes ready one cycle early
// - Reset pin aborts, floats, clears config
// - Reset pin returns machine to read
// - Write of 00F0 anywhere resets bank
// - Reset ignored while embedded operation runs
// - Reset mid program sequence cancels it
// - Suspended bank resets to suspend-read, but to read after erase setup (0080)
// - Reset accepted within identification sequence
// - Buffer abort needs an unlock write (00AA) to recover
// - Bypass left only by two-cycle exit
// - Timing limit flag on pulse overrun
// - Buffer abort flag on aborted buffer
module flash_command_write_and_reset
    import flash_cmd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic reset_pin_n,
    input wire logic chip_enable_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic address_valid_n,
    input wire logic flash_clk,
    input wire logic [23:0] flash_addr,
    input wire logic [15:0] flash_data,
    input wire logic pulse_overrun,
    output logic ready_out,
    output logic ready_oe,
    output logic [15:0] bank_busy
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] ce_s1, we_s1, oe_s1, av_s1, ck_s1, rs_s1;
        logic ce_q, we_q, ck_q;
        logic [23:0] addr_q;
        logic [1:0][23:0] addr_s;
        logic [1:0][15:0] data_s;
        logic [15:0] cfg_q;
        logic [31:0] rdata_q;
        logic timing_limit_flag;
        logic buffer_abort_flag;
        logic [2:0] wait_cnt_q;
        logic burst_q;
        logic [NUM_BANKS-1:0][3:0] bank_q;
        logic [NUM_BANKS-1:0] susp_q;
        logic [6:0] busy_cnt_q;
        logic [3:0] busy_bank_q;
        logic [15:0] last_cmd_q;
        logic [1:0] erase_kind_q;
        logic dphase_q, dwrite_q;
        logic [7:0] daddr_q;
    } state_t;
    state_t s_q, s_d;
    flash_write_t wr;
    logic fall_ce, fall_we, rise_ce, rise_we, rise_ck, wr_strobe, any_fall;
    logic sync_mode;
    bank_state_t bs;

    // Two-stage synchronisers; bit 0 is the first stage only
    always_comb begin
        s_d = s_q;
        s_d.ce_s1 = {s_q.ce_s1[0], chip_enable_n};
        s_d.we_s1 = {s_q.we_s1[0], write_enable_n};
        s_d.oe_s1 = {s_q.oe_s1[0], output_enable_n};
        s_d.av_s1 = {s_q.av_s1[0], address_valid_n};
        s_d.ck_s1 = {s_q.ck_s1[0], flash_clk};
        s_d.rs_s1 = {s_q.rs_s1[0], reset_pin_n};
        s_d.addr_s = {s_q.addr_s[0], flash_addr};
        s_d.data_s = {s_q.data_s[0], flash_data};
        s_d.ce_q = s_q.ce_s1[1];
        s_d.we_q = s_q.we_s1[1];
        s_d.ck_q = s_q.ck_s1[1];
        sync_mode = s_q.cfg_q[CFG_SYNC_BIT];
        fall_ce = s_q.ce_q & ~s_q.ce_s1[1];
        fall_we = s_q.we_q & ~s_q.we_s1[1];
        rise_ce = ~s_q.ce_q & s_q.ce_s1[1];
        rise_we = ~s_q.we_q & s_q.we_s1[1];
        rise_ck = sync_mode & ~s_q.ck_q & s_q.ck_s1[1];
        any_fall = (fall_ce & ~s_q.we_s1[1]) | (fall_we & ~s_q.ce_s1[1]);
        // Address: last falling edge of the two strobes
        if (any_fall & s_q.oe_s1[1]) begin
            s_d.addr_q = s_q.addr_s[1];
        end
        // Sync programming: clock edge with address-valid low
        if (rise_ck & ~s_q.av_s1[1] & ~s_q.ce_s1[1]) begin
            s_d.addr_q = s_q.addr_s[1];
        end
        // Data: first rising edge of either strobe
        wr_strobe = (rise_we & ~s_q.ce_q) | (rise_ce & ~s_q.we_q);
        wr_strobe = wr_strobe & s_q.oe_s1[1];
        wr.bank = s_q.addr_q[BANK_LSB +: 4];
        wr.data = s_q.data_s[1];
        // Ready: counts wait states after a sync read start
        if (sync_mode & rise_ck & ~s_q.av_s1[1]) begin
            s_d.burst_q = 1'b1;
            s_d.wait_cnt_q = s_q.cfg_q[CFG_WAIT_LSB +: 3];
        end else if (rise_ck & s_q.burst_q & (s_q.wait_cnt_q != 3'h0)) begin
            s_d.wait_cnt_q = s_q.wait_cnt_q - 3'h1;
        end
        if (s_q.ce_s1[1]) begin
            s_d.burst_q = 1'b0;
        end
        // Embedded operation timer
        if (s_q.busy_cnt_q != 7'h00) begin
            s_d.busy_cnt_q = s_q.busy_cnt_q - 7'h01;
            if (pulse_overrun) begin
                s_d.timing_limit_flag = 1'b1;
                s_d.busy_cnt_q = 7'h00;
                s_d.bank_q[s_q.busy_bank_q] = BK_FAILED;
            end else if (s_q.busy_cnt_q == 7'h01) begin
                s_d.bank_q[s_q.busy_bank_q] =
                    s_q.susp_q[s_q.busy_bank_q] ? BK_SUSPENDED : BK_READ;
            end
        end
        // Per-bank command machine
        bs = bank_state_t'(s_q.bank_q[wr.bank]);
        if (wr_strobe) begin
            s_d.last_cmd_q = wr.data;
            unique case (bs)
                BK_READ, BK_SUSPENDED: begin
                    if (wr.data == CMD_UNLOCK1) begin
                        s_d.bank_q[wr.bank] = BK_UNL1;
                    end
                end
                BK_UNL1: begin
                    s_d.bank_q[wr.bank] = (wr.data == CMD_UNLOCK2) ? BK_UNL2 :
                        (s_q.susp_q[wr.bank] ? BK_SUSPENDED : BK_READ);
                end
                BK_UNL2: begin
                    unique case (wr.data)
                        CMD_PROGRAM: s_d.bank_q[wr.bank] = BK_PROG_SETUP;
                        CMD_AUTOSEL: s_d.bank_q[wr.bank] = BK_AUTOSEL;
                        CMD_ERASE: s_d.bank_q[wr.bank] = BK_ERASE_SETUP;
                        CMD_BYPASS: s_d.bank_q[wr.bank] = BK_BYPASS;
                        CMD_BUFFER: s_d.bank_q[wr.bank] = BK_BUF_LOAD;
                        default: s_d.bank_q[wr.bank] =
                            s_q.susp_q[wr.bank] ? BK_SUSPENDED : BK_READ;
                    endcase
                end
                BK_PROG_SETUP: begin
                    if (wr.data == CMD_RESET) begin
                        s_d.bank_q[wr.bank] =
                            s_q.susp_q[wr.bank] ? BK_SUSPENDED : BK_READ;
                    end else begin
                        s_d.bank_q[wr.bank] = BK_BUSY;
                        s_d.busy_bank_q = wr.bank;
                        s_d.busy_cnt_q = BUSY_COUNT;
                    end
                end
                BK_ERASE_SETUP: begin
                    s_d.bank_q[wr.bank] = (wr.data == CMD_UNLOCK1) ?
                        BK_ERASE_UNL1 : BK_READ;
                end
                BK_ERASE_UNL1: begin
                    s_d.bank_q[wr.bank] = (wr.data == CMD_UNLOCK2) ?
                        BK_ERASE_UNL2 : BK_READ;
                end
                BK_ERASE_UNL2: begin
                    if (wr.data == CMD_SECTOR || wr.data == CMD_CHIP) begin
                        s_d.erase_kind_q = (wr.data == CMD_CHIP) ? 2'h2 :
                            ((s_q.erase_kind_q != 2'h0) ? 2'h1 : 2'h0);
                        s_d.bank_q[wr.bank] = BK_BUSY;
                        s_d.busy_bank_q = wr.bank;
                        s_d.busy_cnt_q = BUSY_COUNT;
                    end else begin
                        s_d.bank_q[wr.bank] = BK_READ;
                    end
                end
                BK_BUSY: begin
                    // Reset ignored; suspend parks any running operation, program or erase
                    if (wr.data == CMD_SUSPEND && s_q.erase_kind_q != 2'h3) begin
                        s_d.susp_q[wr.bank] = 1'b1;
                        s_d.busy_cnt_q = 7'h00;
                        s_d.bank_q[wr.bank] = BK_SUSPENDED;
                    end
                end
                BK_AUTOSEL, BK_FAILED: begin
                    if (wr.data == CMD_RESET) begin
                        s_d.bank_q[wr.bank] =
                            s_q.susp_q[wr.bank] ? BK_SUSPENDED : BK_READ;
                        s_d.timing_limit_flag &= pulse_overrun;
                    end
                end
                BK_BYPASS: begin
                    // Plain reset has no effect here
                    if (wr.data == CMD_BYPASS_EXIT) begin
                        s_d.bank_q[wr.bank] = BK_BYPASS_EXIT;
                    end
                end
                BK_BYPASS_EXIT: begin
                    s_d.bank_q[wr.bank] = (wr.data == CMD_BYPASS_EXIT2) ?
                        BK_READ : BK_BYPASS;
                end
                BK_BUF_LOAD: begin
                    if (wr.data == CMD_BUF_CONFIRM) begin
                        s_d.bank_q[wr.bank] = BK_BUSY;
                        s_d.busy_bank_q = wr.bank;
                        s_d.busy_cnt_q = BUSY_COUNT;
                    end else if (wr.data == CMD_RESET) begin
                        s_d.bank_q[wr.bank] = BK_BUF_ABORT;
                        s_d.buffer_abort_flag = 1'b1;
                    end
                end
                BK_BUF_ABORT: begin
                    // A single unlock write (00AA) leaves abort and clears the flag
                    if (wr.data == CMD_UNLOCK1) begin
                        s_d.bank_q[wr.bank] = BK_UNL1;
                        s_d.buffer_abort_flag = 1'b0;
                    end
                end
                default: s_d.bank_q[wr.bank] = BK_READ;
            endcase
        end
        // AHB-Lite slave, zero wait states
        s_d.dphase_q = hsel & hready & htrans[1];
        s_d.dwrite_q = hwrite;
        s_d.daddr_q = haddr[7:0];
        if (s_q.dphase_q & s_q.dwrite_q & (s_q.daddr_q == CFG_OFFSET)) begin
            s_d.cfg_q = hwdata[15:0];
        end
        if (s_q.dphase_q & s_q.dwrite_q & (s_q.daddr_q == STATUS_OFFSET)) begin
            if (hwdata[0] & ~(pulse_overrun & (s_q.busy_cnt_q != 7'h00))) begin
                s_d.timing_limit_flag = 1'b0;
            end
        end
        if (hsel & hready & htrans[1] & ~hwrite) begin
            unique case (haddr[7:0])
                CFG_OFFSET: s_d.rdata_q = {16'h0000, s_q.cfg_q};
                STATUS_OFFSET: s_d.rdata_q = {30'h0000_0000,
                    s_q.buffer_abort_flag, s_q.timing_limit_flag};
                OP_OFFSET: s_d.rdata_q = {9'h000, s_q.busy_cnt_q,
                    12'h000, s_q.busy_bank_q};
                LAST_OFFSET: s_d.rdata_q = {16'h0000, s_q.last_cmd_q};
                default: s_d.rdata_q = 32'h0000_0000;
            endcase
        end
        // Reset pin held low: config, banks, suspend, timer, burst and flags back to idle
        if (~s_q.rs_s1[1]) begin
            s_d.cfg_q = CFG_RESET;
            s_d.bank_q = '0;
            s_d.susp_q = '0;
            s_d.busy_cnt_q = 7'h00;
            s_d.burst_q = 1'b0;
            s_d.timing_limit_flag = 1'b0;
            s_d.buffer_abort_flag = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            // Strobe pins idle high, so no false edge follows reset
            {s_q.ce_s1, s_q.we_s1, s_q.ce_q, s_q.we_q} <= 6'h3F;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic rdy_lvl;
    assign rdy_lvl = s_q.burst_q & (s_q.wait_cnt_q <=
        {2'b00, s_q.cfg_q[CFG_RDY_EARLY_BIT]});
    assign ready_out = rdy_lvl ^ ~s_q.cfg_q[CFG_RDY_POL_BIT];
    assign ready_oe = ~s_q.ce_s1[1] & s_q.rs_s1[1];
    assign hrdata = s_q.rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++) begin : g_busy
            assign bank_busy[gi] = (s_q.bank_q[gi] == BK_BUSY);
        end
    endgenerate

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_reset_pin_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        !s_q.rs_s1[1] |=> (s_q.cfg_q == CFG_RESET && s_q.bank_q == '0))
        else $error("reset pin did not clear state");
    a_busy_ignores_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_strobe && bs == BK_BUSY && wr.data == CMD_RESET && s_q.rs_s1[1]
        && !(s_q.busy_cnt_q == 7'h01) && !pulse_overrun
        |=> s_q.bank_q[$past(wr.bank)] == BK_BUSY)
        else $error("reset accepted during embedded op");
    a_ready_gated_ce: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.ce_s1[1] |-> !ready_oe)
        else $error("ready driven with chip disabled");
    a_bypass_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_strobe && bs == BK_BYPASS && wr.data == CMD_RESET && s_q.rs_s1[1]
        |=> s_q.bank_q[$past(wr.bank)] == BK_BYPASS)
        else $error("bypass left by plain reset");
    a_abort_sticks: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_strobe && bs == BK_BUF_ABORT && wr.data == CMD_RESET && s_q.rs_s1[1]
        |=> s_q.buffer_abort_flag)
        else $error("plain reset cleared buffer abort");
    a_overrun_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        pulse_overrun && s_q.busy_cnt_q != 7'h00 && s_q.rs_s1[1]
        |=> s_q.timing_limit_flag)
        else $error("timing limit not raised");
    a_async_no_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        !sync_mode |-> !rise_ck)
        else $error("clock used in async mode");
    a_prog_cancel: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_strobe && bs == BK_PROG_SETUP && wr.data == CMD_RESET
        && !s_q.susp_q[wr.bank] && s_q.rs_s1[1]
        |=> s_q.bank_q[$past(wr.bank)] == BK_READ)
        else $error("program sequence not cancelled");
endmodule : flash_command_write_and_reset
`default_nettype wire
